// *** pkg/uied_defs.svh ***
`ifndef UIED_DEFS_SVH
`define UIED_DEFS_SVH

// baud-tick counter width and its named positions
`define UIED_CNT_W          4
`define UIED_CNT_ZERO       4'h0
`define UIED_CNT_ONE        4'h1
`define UIED_CNT_LAST       4'hF

// transmit slot: low 0..6, high 7..9, low 10..15
`define UIED_TX_PULSE_FIRST 4'h7
`define UIED_TX_PULSE_LAST  4'h9
`define UIED_TX_TAIL_FIRST  4'hA
`define UIED_TX_SAMPLE      4'h8

// receive decoder positions
`define UIED_RX_UPDATE      4'h8
`define UIED_RX_UPDATE_PRE  4'h7
`define UIED_RX_WIN_OPEN    4'hC

// transmit bit buffer
`define UIED_BUF_DEPTH      2
`define UIED_BUF_WIDTH      1

`endif

// *** pkg/uied_pkg.sv ***
`include "uied_defs.svh"

package uied_pkg;

    typedef enum logic [0:0] {
        UIED_RX_IDLE  = 1'b0,
        UIED_RX_TRACK = 1'b1
    } uied_rx_state_type;

    typedef struct packed {
        logic                   active;
        logic                   zero;
        logic [`UIED_CNT_W-1:0] cnt;
        logic                   ir;
    } uied_enc_type;

    typedef struct packed {
        logic                   rx_meta;
        logic                   rx_sync;
        logic                   rx_prev;
        uied_rx_state_type      rx_state;
        logic [`UIED_CNT_W-1:0] rx_cnt;
        logic                   rx_wrap;
        logic                   rx_demod;
        logic [`UIED_CNT_W-1:0] tx_ph;
        logic                   txd_prev;
        logic                   push_valid;
        logic                   push_data;
        logic                   uart_rxd;
        logic                   txd_pin;
    } uied_main_type;

    localparam uied_main_type UIED_MAIN_RST = '{
        rx_meta: 1'h1, rx_sync: 1'h1, rx_prev: 1'h1,
        rx_state: UIED_RX_IDLE, rx_demod: 1'h1,
        txd_prev: 1'h1, uart_rxd: 1'h1, default: '0};

endpackage

// *** verilog/uied_bit_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uied_defs.svh"

module uied_bit_fifo #(
    parameter int WIDTH = `UIED_BUF_WIDTH,
    parameter int DEPTH = `UIED_BUF_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } uied_fifo_type;

    uied_fifo_type q, d;
    logic          push;
    logic          pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
    endfunction

    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = next_ptr(q.wp);
        end
        if (pop) begin
            d.rp = next_ptr(q.rp);
        end
        d.cnt = (AW+1)'(q.cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop});
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // uied_bit_fifo

`default_nettype wire

// *** verilog/uied_ir_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uied_defs.svh"

module uied_ir_encoder
    import uied_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic baud_tick,
    input  wire logic bit_valid,
    input  wire logic bit_data,
    output logic      bit_ready,
    output logic      ir_out,
    output logic      zero_busy
);
    uied_enc_type q, d;

    // a new bit is taken only at a slot boundary, so slots never shorten
    assign bit_ready = baud_tick & (~q.active | (q.cnt == `UIED_CNT_LAST));
    assign ir_out    = q.ir;
    assign zero_busy = q.active & q.zero;

    always_comb begin
        d = q;
        if (bit_ready) begin
            d.active = bit_valid;
            d.zero   = bit_valid & ~bit_data;
            d.cnt    = `UIED_CNT_ZERO;
        end else if (baud_tick) begin
            d.cnt = q.cnt + `UIED_CNT_ONE;
        end
        d.ir = d.active & d.zero & (d.cnt >= `UIED_TX_PULSE_FIRST)
             & (d.cnt <= `UIED_TX_PULSE_LAST); // R2 R3
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking enc_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_one_stays_low;
        (q.active & ~q.zero) |-> !ir_out;
    endproperty
    a_one_stays_low: assert property (p_one_stays_low) else $error("pulse in a one bit"); // R1

    property p_pulse_starts_at_seven;
        $rose(ir_out) |-> (q.cnt == `UIED_TX_PULSE_FIRST) && zero_busy;
    endproperty
    a_pulse_starts_at_seven: assert property (p_pulse_starts_at_seven) else $error("pulse start off"); // R2

    property p_pulse_ends_at_ten;
        $fell(ir_out) && q.active |-> q.cnt == `UIED_TX_TAIL_FIRST;
    endproperty
    a_pulse_ends_at_ten: assert property (p_pulse_ends_at_ten) else $error("pulse end off"); // R3
endmodule // uied_ir_encoder

`default_nettype wire

// *** verilog/uied_endec.sv ***
// Overview of operation
// R1: a one bit is sent as sixteen baud periods of steady low.
// R2: a zero bit starts with seven low periods then three high.
// R3: after the high pulse, six more low periods finish the zero bit.
// R4: half duplex; own transmission blanks the decoder, far end must wait.
// R5: software keeps the UART enabled while the codec is used.
// R6: bit rate is system clock over sixteen times the baud divisor.
// R7: standard rates 9600 to 115.2 Kbaud; faster rates still work.
// R8: with codec enabled the modulated signal, not raw UART data, drives tx pin.
// R9: with codec enabled the rx pin feeds the decoder, decoder feeds UART.
// R10: decoder counts baud periods from 0 to 15.
// R11: demodulated output lags incoming pulses by eight baud periods.
// R12: an accepted falling edge resets the decoder counter to zero.
// R13: at count 8 the demodulated output takes the decoded bit.
// R14: window opens at count 12, closes at count 8 after wrap.
// R15: pulses accepted from four before to eight after the expected time.
// R16: pulse in window repeats decoding; none means one and idle.
// R17: decoder resync never disturbs the UART receive line.
// R18: system clock at least 1.0MHz for 1.6us pulses.
// R19: no registers; enable arrives from the UART control logic.
// R20: software enables the codec before selecting the pin function.
// R21: software picks divisor as rounded clock over sixteen times rate.
// R22: with codec disabled, tx and rx pass straight through.
`timescale 1ns/1ps
`default_nettype none
`include "uied_defs.svh"

module uied_endec
    import uied_pkg::*;
#(
    parameter int BUF_DEPTH = `UIED_BUF_DEPTH
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic baud_tick,
    input  wire logic infrared_codec_enable, // R19
    input  wire logic uart_txd,
    output logic      uart_rxd,
    output logic      infrared_modulated_tx,
    input  wire logic infrared_modulated_rx
);
    uied_main_type q, d;

    logic                   fall;
    logic                   window;
    logic                   blank;
    logic                   enc_busy;
    logic                   enc_ir;
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic                   buf_out_data;
    logic                   enc_ready;
    logic [`UIED_CNT_W-1:0] rx_inc;
    logic [`UIED_CNT_W-1:0] tx_inc;

    function automatic logic [`UIED_CNT_W-1:0] cnt_inc(input logic [`UIED_CNT_W-1:0] c);
        cnt_inc = c + `UIED_CNT_ONE;
    endfunction

    // sampled UART bits wait here while the encoder finishes a slot
    uied_bit_fifo #(
        .WIDTH (`UIED_BUF_WIDTH),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (q.push_valid),
        .in_data   (q.push_data),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (enc_ready)
    );

    uied_ir_encoder u_enc (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .baud_tick (baud_tick),
        .bit_valid (buf_out_valid),
        .bit_data  (buf_out_data),
        .bit_ready (enc_ready),
        .ir_out    (enc_ir),
        .zero_busy (enc_busy)
    );

    assign fall   = q.rx_prev & ~q.rx_sync;
    assign window = q.rx_wrap | (q.rx_cnt >= `UIED_RX_WIN_OPEN); // R14 R15
    // own pulses echo back through the optics, so they are never decoded
    assign blank  = enc_busy | ~infrared_codec_enable; // R4
    assign rx_inc = cnt_inc(q.rx_cnt);
    // no rate limit inside; any tick spacing the UART gives is followed
    assign tx_inc = cnt_inc(q.tx_ph); // R7

    assign uart_rxd              = q.uart_rxd;
    assign infrared_modulated_tx = q.txd_pin;

    always_comb begin
        d = q;

        // pin synchroniser, first stage feeds only the second
        d.rx_meta = infrared_modulated_rx;
        d.rx_sync = q.rx_meta;
        d.rx_prev = q.rx_sync;

        case (q.rx_state)
            UIED_RX_IDLE: begin
                d.rx_demod = 1'h1;
                if (fall && !blank) begin
                    d.rx_state = UIED_RX_TRACK;
                    d.rx_cnt   = `UIED_CNT_ZERO; // R12
                    d.rx_wrap  = 1'h0;
                end
            end
            UIED_RX_TRACK: begin
                if (blank) begin
                    d.rx_state = UIED_RX_IDLE;
                    d.rx_cnt   = `UIED_CNT_ZERO;
                    d.rx_wrap  = 1'h0;
                    d.rx_demod = 1'h1;
                end else if (fall && window) begin
                    // resync only zeroes the counter and wrap flag, output is untouched
                    d.rx_cnt  = `UIED_CNT_ZERO; // R12 R16 R17
                    d.rx_wrap = 1'h0;
                end else if (baud_tick) begin
                    d.rx_cnt = rx_inc; // R10
                    if (q.rx_cnt == `UIED_CNT_LAST) begin
                        d.rx_wrap = 1'h1;
                    end
                    if (rx_inc == `UIED_RX_UPDATE) begin
                        if (q.rx_wrap) begin
                            d.rx_demod = 1'h1; // R16
                            d.rx_state = UIED_RX_IDLE;
                            d.rx_cnt   = `UIED_CNT_ZERO;
                            d.rx_wrap  = 1'h0;
                        end else begin
                            d.rx_demod = 1'h0; // R11 R13
                        end
                    end
                end
            end
            default: begin
                d.rx_state = UIED_RX_IDLE;
                d.rx_cnt   = `UIED_CNT_ZERO;
                d.rx_wrap  = 1'h0;
                d.rx_demod = 1'h1;
            end
        endcase

        // transmit bit phase, realigned to every falling edge of uart_txd, data bits included
        d.txd_prev = uart_txd;
        if (q.txd_prev && !uart_txd) begin
            d.tx_ph = `UIED_CNT_ZERO;
        end else if (baud_tick) begin
            d.tx_ph = tx_inc; // R6
        end
        if (q.push_valid && buf_in_ready) begin
            d.push_valid = 1'h0;
        end
        // mid-bit sample; a pending push is kept rather than overwritten
        if (infrared_codec_enable && baud_tick && tx_inc == `UIED_TX_SAMPLE
            && !(q.push_valid && !buf_in_ready)) begin
            d.push_valid = 1'h1;
            d.push_data  = uart_txd;
        end

        if (infrared_codec_enable) begin
            d.txd_pin  = enc_ir; // R8
            d.uart_rxd = q.rx_demod; // R9
        end else begin
            d.txd_pin  = uart_txd; // R22
            d.uart_rxd = q.rx_sync; // R22
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= UIED_MAIN_RST;
        end else begin
            q <= d;
        end
    end

    default clocking main_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_tx_pin_modulated;
        $past(infrared_codec_enable) && !$past(enc_ir) |-> !infrared_modulated_tx;
    endproperty
    a_tx_pin_modulated: assert property (p_tx_pin_modulated) else $error("raw tx leaked"); // R8

    property p_rx_from_decoder;
        infrared_codec_enable |=> uart_rxd == $past(q.rx_demod);
    endproperty
    a_rx_from_decoder: assert property (p_rx_from_decoder) else $error("rx not demodulated"); // R9

    property p_bypass;
        !infrared_codec_enable |=> infrared_modulated_tx == $past(uart_txd)
                                   && uart_rxd == $past(q.rx_sync);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // R22

    property p_blank_while_tx;
        enc_busy |=> q.rx_state == UIED_RX_IDLE;
    endproperty
    a_blank_while_tx: assert property (p_blank_while_tx) else $error("decoding own echo"); // R4

    property p_count_step;
        q.rx_state == UIED_RX_TRACK && baud_tick && !fall && !blank
            && rx_inc != `UIED_RX_UPDATE |=> q.rx_cnt == $past(rx_inc);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step"); // R10

    property p_resync_zero;
        q.rx_state == UIED_RX_TRACK && fall && window && !blank
            |=> q.rx_cnt == `UIED_CNT_ZERO && !q.rx_wrap;
    endproperty
    a_resync_zero: assert property (p_resync_zero) else $error("no resync"); // R12

    property p_update_zero;
        q.rx_state == UIED_RX_TRACK && !q.rx_wrap && baud_tick && !fall && !blank
            && q.rx_cnt == `UIED_RX_UPDATE_PRE |=> !q.rx_demod ##1 !uart_rxd;
    endproperty
    a_update_zero: assert property (p_update_zero) else $error("zero not decoded at 8"); // R11 R13

    property p_window_closed;
        q.rx_state == UIED_RX_TRACK && fall && !window && !blank && !baud_tick
            |=> q.rx_cnt == $past(q.rx_cnt);
    endproperty
    a_window_closed: assert property (p_window_closed) else $error("edge outside window"); // R14 R15

    property p_no_pulse_is_one;
        q.rx_state == UIED_RX_TRACK && q.rx_wrap && baud_tick && !fall && !blank
            && q.rx_cnt == `UIED_RX_UPDATE_PRE |=> q.rx_demod && q.rx_state == UIED_RX_IDLE;
    endproperty
    a_no_pulse_is_one: assert property (p_no_pulse_is_one) else $error("missing one"); // R16

    property p_resync_keeps_output;
        q.rx_state == UIED_RX_TRACK && fall && window && !blank
            |=> $stable(q.rx_demod);
    endproperty
    a_resync_keeps_output: assert property (p_resync_keeps_output) else $error("resync moved rxd"); // R17

    property p_idle_output_high;
        q.rx_state == UIED_RX_IDLE |-> q.rx_demod;
    endproperty
    a_idle_output_high: assert property (p_idle_output_high) else $error("idle not one"); // R16

    property p_idle_count_zero;
        q.rx_state == UIED_RX_IDLE |-> q.rx_cnt == `UIED_CNT_ZERO && !q.rx_wrap;
    endproperty
    a_idle_count_zero: assert property (p_idle_count_zero) else $error("idle count left"); // R10

    property p_wrap_sets;
        q.rx_state == UIED_RX_TRACK && baud_tick && !fall && !blank
            && q.rx_cnt == `UIED_CNT_LAST |=> q.rx_wrap;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("wrap not marked"); // R14

    property p_enter_track;
        q.rx_state == UIED_RX_IDLE && fall && !blank
            |=> q.rx_state == UIED_RX_TRACK && q.rx_cnt == `UIED_CNT_ZERO;
    endproperty
    a_enter_track: assert property (p_enter_track) else $error("edge not tracked"); // R12

    property p_disabled_idle;
        !infrared_codec_enable |=> q.rx_state == UIED_RX_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("decoding while off"); // R22

    property p_demod_fall_at_eight;
        $fell(q.rx_demod) |-> q.rx_cnt == `UIED_RX_UPDATE && q.rx_state == UIED_RX_TRACK;
    endproperty
    a_demod_fall_at_eight: assert property (p_demod_fall_at_eight) else $error("zero off 8"); // R13

    property p_demod_rise_idle;
        $rose(q.rx_demod) |-> q.rx_state == UIED_RX_IDLE;
    endproperty
    a_demod_rise_idle: assert property (p_demod_rise_idle) else $error("one not idle"); // R16

    // once wrapped, the count never passes the update point
    property p_wrap_range;
        q.rx_state == UIED_RX_TRACK && q.rx_wrap |-> q.rx_cnt <= `UIED_RX_UPDATE_PRE;
    endproperty
    a_wrap_range: assert property (p_wrap_range) else $error("window overran"); // R14

    property p_one_bit_low;
        infrared_codec_enable && !enc_busy |=> !infrared_modulated_tx;
    endproperty
    a_one_bit_low: assert property (p_one_bit_low) else $error("pulse outside zero"); // R1

    property p_push_on_sample;
        infrared_codec_enable && baud_tick && tx_inc == `UIED_TX_SAMPLE
            && !(q.push_valid && !buf_in_ready)
            |=> q.push_valid && q.push_data == $past(uart_txd);
    endproperty
    a_push_on_sample: assert property (p_push_on_sample) else $error("mid-bit sample lost"); // R6

    property p_phase_align;
        q.txd_prev && !uart_txd |=> q.tx_ph == `UIED_CNT_ZERO;
    endproperty
    a_phase_align: assert property (p_phase_align) else $error("phase not aligned"); // R6

    property p_track_step_wrap;
        q.rx_state == UIED_RX_TRACK && baud_tick && !fall && !blank
            && q.rx_cnt == `UIED_CNT_LAST |=> q.rx_cnt == `UIED_CNT_ZERO;
    endproperty
    a_track_step_wrap: assert property (p_track_step_wrap) else $error("count not 0..15"); // R10

    c_pulse_sent: cover property ($rose(infrared_modulated_tx));
    c_zero_decoded: cover property ($fell(uart_rxd) && infrared_codec_enable);
    c_resync: cover property (q.rx_state == UIED_RX_TRACK && fall && q.rx_wrap);
    c_back_to_idle: cover property (q.rx_state == UIED_RX_TRACK ##1 q.rx_state == UIED_RX_IDLE);
endmodule // uied_endec

`default_nettype wire

// *** dv/uied_irx_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module uied_irx_model (
    input  wire logic clk_sys,
    input  wire logic baud_tick,
    input  wire logic ir_tx,
    output logic      ir_rx
);
    int   cyc       = 0;
    int   rises     = 0;
    int   last_rise = 0;
    int   prev_rise = 0;
    int   width     = 0;
    int   t_fall    = 0;
    logic tx_q      = 1'b0;

    // receiver output idles high, a received pulse pulls it low
    initial begin
        ir_rx = 1'b1;
    end

    always @(posedge clk_sys) begin
        cyc  <= cyc + 1;
        tx_q <= ir_tx;
        if (ir_tx === 1'b1 && tx_q === 1'b0) begin
            rises     <= rises + 1;
            prev_rise <= last_rise;
            last_rise <= cyc;
        end
        if (ir_tx === 1'b0 && tx_q === 1'b1) begin
            width <= cyc - last_rise;
        end
    end

    task automatic wait_tick();
        @(posedge clk_sys);
        while (baud_tick !== 1'b1) begin
            @(posedge clk_sys);
        end
    endtask

    task automatic clear();
        @(posedge clk_sys);
        rises <= 0;
    endtask

    task automatic set_rx(input logic v);
        @(posedge clk_sys);
        ir_rx <= v;
    endtask

    // pulse of 3 ticks, many system clocks wide so it is never missed
    task automatic send_pulse();
        while (ir_tx !== 1'b0) begin
            @(posedge clk_sys);
        end
        wait_tick();
        ir_rx  <= 1'b0;
        t_fall = cyc;
        repeat (3) wait_tick();
        ir_rx <= 1'b1;
    endtask
endmodule // uied_irx_model

`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // divisor picked as clock over sixteen times the wanted rate
    localparam int DIV   = 4;
    localparam int LIMIT = 20000;

    logic clk_sys;
    logic rst_n;
    logic baud_tick = 1'b0;
    logic infrared_codec_enable;
    logic uart_txd;
    logic uart_rxd;
    logic infrared_modulated_tx;
    logic infrared_modulated_rx;
    int   bad_count = 0;
    int   compares  = 0;
    int   cycles    = 0;
    int   tick_cnt  = 0;

    uied_endec uut (
        .clk_sys               (clk_sys),
        .rst_n                 (rst_n),
        .baud_tick             (baud_tick),
        .infrared_codec_enable (infrared_codec_enable),
        .uart_txd              (uart_txd),
        .uart_rxd              (uart_rxd),
        .infrared_modulated_tx (infrared_modulated_tx),
        .infrared_modulated_rx (infrared_modulated_rx)
    );

    uied_irx_model far_end (
        .clk_sys   (clk_sys),
        .baud_tick (baud_tick),
        .ir_tx     (infrared_modulated_tx),
        .ir_rx     (infrared_modulated_rx)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // 16x baud enable, one clock wide every DIV clocks; the UART stays enabled
    always @(posedge clk_sys) begin
        tick_cnt  <= (tick_cnt == DIV - 1) ? 0 : tick_cnt + 1;
        baud_tick <= (tick_cnt == DIV - 1);
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("[FAIL] run time expected below %0d seen %0d", LIMIT, cycles);
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    function automatic logic in_range(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi);
    endfunction

    task automatic wait_ticks(input int n);
        repeat (n) far_end.wait_tick();
    endtask

    // bounded wait; -1 if the level never shows
    task automatic wait_rxd(input logic v, output int t);
        t = -1;
        for (int n = 0; n < 400; n++) begin
            @(posedge clk_sys);
            if (uart_rxd === v) begin
                t = far_end.cyc;
                break;
            end
        end
    endtask

    task automatic test_bypass();
        @(posedge clk_sys);
        infrared_codec_enable <= 1'b0;
        uart_txd              <= 1'b0;
        @(posedge clk_sys);
        #1 check("tx pin follows txd low", infrared_modulated_tx, 1'b0);
        @(posedge clk_sys);
        uart_txd <= 1'b1;
        @(posedge clk_sys);
        #1 check("tx pin follows txd high", infrared_modulated_tx, 1'b1);
        far_end.set_rx(1'b0);
        repeat (5) @(posedge clk_sys);
        #1 check("rxd follows pin low", uart_rxd, 1'b0);
        far_end.set_rx(1'b1);
        repeat (5) @(posedge clk_sys);
        #1 check("rxd follows pin high", uart_rxd, 1'b1);
    endtask

    // bits 0,1,0: two pulses one slot pair apart, one-bit slot stays low
    task automatic test_tx();
        @(posedge clk_sys);
        infrared_codec_enable <= 1'b1;
        far_end.clear();
        wait_ticks(20);
        check("tx pin idle with txd high", infrared_modulated_tx, 1'b0);
        uart_txd <= 1'b0;
        wait_ticks(16);
        uart_txd <= 1'b1;
        wait_ticks(16);
        uart_txd <= 1'b0;
        wait_ticks(16);
        uart_txd <= 1'b1;
        wait_ticks(60);
        check("tx pulse count", far_end.rises, 32'h2);
        check("tx pulse width", far_end.width, 3 * DIV);
        check("tx pulse spacing", far_end.last_rise - far_end.prev_rise, 32 * DIV);
        check("tx pin low after bits", infrared_modulated_tx, 1'b0);
    endtask

    task automatic test_rx_train();
        int t0;
        int t;
        @(posedge clk_sys);
        far_end.send_pulse();
        t0 = far_end.t_fall;
        check("rxd not raw pin", uart_rxd, 1'b1);
        wait_rxd(1'b0, t);
        check("rxd fall lag", in_range(t - t0, 8 * DIV, 9 * DIV + 6), 1'b1);
        wait_ticks(7);
        far_end.send_pulse();
        check("rxd held through next pulse", uart_rxd, 1'b0);
        t0 = far_end.t_fall;
        wait_rxd(1'b1, t);
        check("rxd rise after last pulse", in_range(t - t0, 24 * DIV, 25 * DIV + 8), 1'b1);
    endtask

    task automatic test_window();
        int t0;
        int t;
        @(posedge clk_sys);
        far_end.send_pulse();
        t0 = far_end.t_fall;
        wait_ticks(6);
        // offset 10 lies before the window and is dropped
        far_end.send_pulse();
        wait_rxd(1'b1, t);
        check("early pulse ignored", in_range(t - t0, 24 * DIV, 25 * DIV + 8), 1'b1);
        wait_ticks(40);
        far_end.send_pulse();
        wait_ticks(9);
        // offset 13 lies inside the window and resyncs
        far_end.send_pulse();
        t0 = far_end.t_fall;
        wait_rxd(1'b1, t);
        check("jittered pulse accepted", in_range(t - t0, 24 * DIV, 25 * DIV + 8), 1'b1);
    endtask

    task automatic end_sim();
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n                 = 1'b0;
        infrared_codec_enable = 1'b0;
        uart_txd              = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // codec still disabled, so the idle-high txd passes straight out
        #1 check("rxd after reset", uart_rxd, 1'b1);
        check("tx pin after reset", infrared_modulated_tx, 1'b1);
        test_bypass();
        test_tx();
        test_rx_train();
        test_window();
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
